// [rbrc_pkg.sv]
/*
 * Package for the ROM board read control block: sync vector layout,
 * APB register offsets, field positions and reset values, state record.
 * Assumes a 200 MHz pclk and 32-bit APB data.
 */
package rbrc_pkg;

   // Synchronised input vector layout
   localparam int SV_W = 40;
   localparam int SV_ADR = 0;
   localparam int SV_MRDC = 20;
   localparam int SV_INH2 = 21;
   localparam int SV_BHEN = 22;
   localparam int SV_CCLK = 23;
   localparam int SV_LOW = 24;
   localparam int SV_HIGH = 32;

   // APB register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SEG_OFS = 8'h04;
   localparam logic [7:0] PAGE_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;

   // CTRL fields
   localparam int CTRL_MODE16 = 0;
   localparam int CTRL_DSIZE = 1;
   localparam int CTRL_ACC = 4;
   localparam int CTRL_OVL = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_00F0;

   // SEG fields: low half enables bank A/B, high half bank C/D
   localparam int SEG_CD = 16;
   localparam logic [31:0] SEG_RST = 32'h0000_0000;

   // PAGE fields
   localparam int PAGE_X = 0;
   localparam int PAGE_Y = 4;
   localparam int PAGE_A = 8;
   localparam int PAGE_B = 9;
   localparam int PAGE_C = 10;
   localparam int PAGE_DROW = 12;
   localparam logic [31:0] PAGE_RST = 32'h0000_0000;

   // Access time for a bank flagged as overlapping RAM
   localparam logic [3:0] OVERLAP_COUNT = 4'hF;

   // Device size codes
   localparam logic [1:0] DSIZE_1K = 2'h0;
   localparam logic [1:0] DSIZE_2K = 2'h1;

   typedef struct packed {
      logic [SV_W-1:0] s1;
      logic [SV_W-1:0] s2;
      logic [SV_W-1:0] s3;
      logic [SV_W-1:0] filt;
      logic cclk_prev;
      logic [3:0] count;
      logic xack;
      logic [31:0] ctrl;
      logic [31:0] seg;
      logic [31:0] page;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [15:0] dout;
      logic [1:0] dout_oe_n;
      logic xack_n;
      logic xack_oe_n;
      logic inh1_n;
      logic inh1_oe_n;
      logic upper_half;
      logic [3:0] row_sel;
      logic cs_en;
      logic [13:0] iaddr;
   } rbrc_state_t;

endpackage : rbrc_pkg

// [rbrc_top.sv]
/*
 * ROM board read control: board select, page and base decode, chip
 * select, access-time counter with acknowledge, byte-lane gating.
 * Assumes bus pins arrive asynchronously to pclk and that the jumper
 * settings are loaded over APB before reads are made.
 */
`timescale 1ns/1ps

// Function
// - Upper half select for banks C/D
// - Internal upper address picks one row
// - Qualifier needs read command and board hit
// - Inhibit clears counter, flop, holds inhibit-out off
// - Counter and flop step on constant clock
// - Byte-high enable honoured only in 16/8 mode
// - Read gate clears counter and flop
// - Acknowledge driven only while qualifier true
// - Low buffer gate driver alone on swap, both otherwise
// - Counter output sets acknowledge on rising edge
// - Sixteen 4K segments form half select
// - 16/8 mode pairs A/B and C/D
// - Page lines compared to pages X and Y
// - A, B, C whole page; D rows individual
// - Byte routing to low/high internal buses
// - Data inverted onto system bus
// - Odd byte swapped onto low lines
// - Both lanes driven on word access
// - Hit drives inhibit-out; overlap forces 15 counts
// - Acknowledge at preset or maximum count
// - 16/8 mode shifts address, bit 0 lane
module rbrc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [19:0] adr_n,
   input wire logic mrdc_n,
   input wire logic inh2_n,
   input wire logic bhen_n,
   input wire logic cclk_n,
   input wire logic [7:0] internal_low_byte_bus,
   input wire logic [7:0] internal_high_byte_bus,
   output logic [15:0] dat_n_o,
   output logic [1:0] dat_oe_n,
   output logic xack_n_o,
   output logic xack_oe_n,
   output logic inh1_n_o,
   output logic inh1_oe_n,
   output logic upper_half_select,
   output logic [3:0] row_select,
   output logic chip_select_enable,
   output logic [13:0] internal_addr
);

   rbrc_pkg::rbrc_state_t st_r;
   rbrc_pkg::rbrc_state_t st_nxt;

   function automatic logic [15:0] seg_decode(input logic [3:0] a);
      seg_decode = 16'h0001 << a;
   endfunction : seg_decode

   function automatic logic [3:0] row_decode(input logic [1:0] a);
      row_decode = 4'h1 << a;
   endfunction : row_decode

   logic [19:0] adr;
   logic mode16;
   logic [1:0] dsize;
   logic [3:0] acc_preset;
   logic [3:0] overlap;
   logic read_cmd;
   logic inhibit;
   logic bhen;
   logic byte_lane_bit;
   logic [13:0] iaddr;
   logic internal_addr_bit0;
   logic internal_addr_row_bit0;
   logic internal_addr_row_bit3;
   logic [1:0] row;
   logic low_word_select;
   logic [15:0] seg_hits;
   logic hit_ab;
   logic hit_cd;
   logic upper;
   logic page_bit;
   logic [3:0] page_target;
   logic page_hit;
   logic board_read_qualifier;
   logic [1:0] bank;
   logic [3:0] target;
   logic cclk_rise;
   logic swap;
   logic [7:0] low_lane;
   logic [7:0] high_lane;
   logic apb_acc;
   logic mapped;
   logic [31:0] rd_val;
   logic [rbrc_pkg::SV_W-1:0] agree;

   always_comb begin
      st_nxt = st_r;

      // Three-stage input synchroniser, filtered on agreement
      st_nxt.s1 = {internal_high_byte_bus, internal_low_byte_bus,
                   cclk_n, bhen_n, inh2_n, mrdc_n, adr_n};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      agree = ~(st_r.s2 ^ st_r.s3);
      st_nxt.filt = (st_r.s2 & agree) | (st_r.filt & ~agree);

      adr = ~st_r.filt[rbrc_pkg::SV_ADR +: 20];
      read_cmd = ~st_r.filt[rbrc_pkg::SV_MRDC];
      inhibit = ~st_r.filt[rbrc_pkg::SV_INH2];
      mode16 = st_r.ctrl[rbrc_pkg::CTRL_MODE16];
      dsize = st_r.ctrl[rbrc_pkg::CTRL_DSIZE +: 2];
      acc_preset = st_r.ctrl[rbrc_pkg::CTRL_ACC +: 4];
      overlap = st_r.ctrl[rbrc_pkg::CTRL_OVL +: 4];

      // Lane enable only in 16/8 mode
      bhen = mode16 & ~st_r.filt[rbrc_pkg::SV_BHEN];

      byte_lane_bit = adr[0];
      iaddr = mode16 ? adr[14:1] : adr[13:0];
      internal_addr_bit0 = iaddr[0];
      internal_addr_row_bit0 = iaddr[10];
      internal_addr_row_bit3 = iaddr[13];

      // Row from upper internal lines by device size
      unique case (dsize)
         rbrc_pkg::DSIZE_1K: row = {iaddr[11], internal_addr_row_bit0};
         rbrc_pkg::DSIZE_2K: row = iaddr[12:11];
         default: row = {internal_addr_row_bit3, iaddr[12]};
      endcase

      // Bank A/C versus B/D in 8-bit mode
      unique case (dsize)
         rbrc_pkg::DSIZE_1K: low_word_select = ~iaddr[12];
         rbrc_pkg::DSIZE_2K: low_word_select = ~iaddr[13];
         default: low_word_select = ~adr[14];
      endcase

      seg_hits = seg_decode(adr[15:12]);
      hit_ab = |(seg_hits & st_r.seg[15:0]);
      hit_cd = |(seg_hits & st_r.seg[rbrc_pkg::SEG_CD +: 16]);
      upper = hit_cd;

      // Page assignment per bank or D row
      if (!upper) begin
         page_bit = (mode16 || low_word_select) ?
                    st_r.page[rbrc_pkg::PAGE_A] : st_r.page[rbrc_pkg::PAGE_B];
      end else if (!mode16 && low_word_select) begin
         page_bit = st_r.page[rbrc_pkg::PAGE_C];
      end else begin
         page_bit = st_r.page[rbrc_pkg::PAGE_DROW + {30'd0, row}];
      end
      // Page lines against X or Y
      page_target = page_bit ? st_r.page[rbrc_pkg::PAGE_Y +: 4] :
                               st_r.page[rbrc_pkg::PAGE_X +: 4];
      page_hit = adr[19:16] == page_target;

      board_read_qualifier = read_cmd & (hit_ab | hit_cd) & page_hit &
                             ~inhibit;

      // Paired banks share one overlap check
      bank = {upper, ~mode16 & ~low_word_select};
      target = (overlap[bank] || (mode16 && overlap[{upper, 1'b1}])) ?
               rbrc_pkg::OVERLAP_COUNT : acc_preset;

      // Steps on the constant clock rising edge
      cclk_rise = st_r.filt[rbrc_pkg::SV_CCLK] & ~st_r.cclk_prev;
      st_nxt.cclk_prev = st_r.filt[rbrc_pkg::SV_CCLK];

      // Read gate clears counter and flop
      if (!board_read_qualifier) begin
         st_nxt.count = 4'h0;
         st_nxt.xack = 1'b0;
      end else if (cclk_rise && !st_r.xack) begin
         // Set at preset or maximum count
         if (st_r.count >= target) begin
            st_nxt.xack = 1'b1;
         end else begin
            st_nxt.count = st_r.count + 4'h1;
         end
      end

      st_nxt.xack_oe_n = ~board_read_qualifier;
      // Released as soon as read command drops
      st_nxt.xack_n = ~(st_nxt.xack & board_read_qualifier);
      st_nxt.inh1_oe_n = ~board_read_qualifier;
      st_nxt.inh1_n = ~board_read_qualifier;

      st_nxt.cs_en = board_read_qualifier;
      st_nxt.upper_half = upper;
      st_nxt.row_sel = board_read_qualifier ? row_decode(row) : 4'h0;
      st_nxt.iaddr = iaddr;

      // Array buses: even/A,C low, odd/B,D high
      low_lane = st_r.filt[rbrc_pkg::SV_LOW +: 8];
      high_lane = st_r.filt[rbrc_pkg::SV_HIGH +: 8];

      swap = ~bhen & (mode16 ? byte_lane_bit : ~low_word_select);
      // Low-lane driver alone on swap, both drivers otherwise
      if (!board_read_qualifier) begin
         st_nxt.dout_oe_n = 2'b11;
         st_nxt.dout = 16'hFFFF;
      end else if (swap) begin
         st_nxt.dout_oe_n = 2'b10;
         st_nxt.dout = {8'hFF, ~high_lane};
      end else begin
         st_nxt.dout_oe_n = 2'b00;
         st_nxt.dout = ~{high_lane, low_lane};
      end

      // APB slave with one wait cycle
      apb_acc = psel & penable & ~st_r.pready;
      mapped = paddr == rbrc_pkg::CTRL_OFS || paddr == rbrc_pkg::SEG_OFS ||
               paddr == rbrc_pkg::PAGE_OFS || paddr == rbrc_pkg::STAT_OFS;
      unique case (paddr)
         rbrc_pkg::CTRL_OFS: rd_val = {20'd0, st_r.ctrl[11:0]};
         rbrc_pkg::SEG_OFS: rd_val = st_r.seg;
         rbrc_pkg::PAGE_OFS: rd_val = {16'd0, st_r.page[15:0]};
         rbrc_pkg::STAT_OFS: rd_val = {24'd0, st_r.count, inhibit,
                                       upper, st_r.xack,
                                       board_read_qualifier};
         default: rd_val = 32'h0000_0000;
      endcase
      st_nxt.pready = apb_acc;
      st_nxt.pslverr = apb_acc & ~mapped;
      if (apb_acc && !pwrite) begin
         st_nxt.prdata = rd_val;
      end
      if (psel && penable && st_r.pready && pwrite) begin
         unique case (paddr)
            rbrc_pkg::CTRL_OFS: st_nxt.ctrl = {20'd0, pwdata[11:0]};
            rbrc_pkg::SEG_OFS: st_nxt.seg = pwdata;
            rbrc_pkg::PAGE_OFS: st_nxt.page = {16'd0, pwdata[15:0]};
            default: st_nxt.ctrl = st_r.ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{s1: '1, s2: '1, s3: '1, filt: '1, cclk_prev: 1'b1,
                   count: 4'h0, xack: 1'b0,
                   ctrl: rbrc_pkg::CTRL_RST, seg: rbrc_pkg::SEG_RST,
                   page: rbrc_pkg::PAGE_RST, prdata: 32'h0000_0000,
                   pready: 1'b0, pslverr: 1'b0, dout: 16'hFFFF,
                   dout_oe_n: 2'b11, xack_n: 1'b1, xack_oe_n: 1'b1,
                   inh1_n: 1'b1, inh1_oe_n: 1'b1, upper_half: 1'b0,
                   row_sel: 4'h0, cs_en: 1'b0, iaddr: 14'h0000};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign dat_n_o = st_r.dout;
   assign dat_oe_n = st_r.dout_oe_n;
   assign xack_n_o = st_r.xack_n;
   assign xack_oe_n = st_r.xack_oe_n;
   assign inh1_n_o = st_r.inh1_n;
   assign inh1_oe_n = st_r.inh1_oe_n;
   assign upper_half_select = st_r.upper_half;
   assign row_select = st_r.row_sel;
   assign chip_select_enable = st_r.cs_en;
   assign internal_addr = st_r.iaddr;

endmodule : rbrc_top

// [rbrc_top_sva.sv]
/*
 * Checker for the ROM board read control block ports.
 * Assumes pclk and active-low presetn of the block; bound below.
 */
`timescale 1ns/1ps
module rbrc_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic inh2_n,
   input wire logic [1:0] dat_oe_n,
   input wire logic xack_n_o,
   input wire logic xack_oe_n,
   input wire logic inh1_n_o,
   input wire logic inh1_oe_n,
   input wire logic [3:0] row_select,
   input wire logic chip_select_enable
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence qual_up;
      $rose(chip_select_enable);
   endsequence
   sequence qual_down;
      $fell(chip_select_enable);
   endsequence
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   qual_rows_a: assert property (!chip_select_enable |-> row_select == 4'h0)
      else $error("row without qualifier");
   one_row_a: assert property (chip_select_enable |-> $onehot(row_select))
      else $error("row select not one-hot");
   ack_gate_a: assert property (!xack_oe_n |-> chip_select_enable)
      else $error("ack driven unqualified");
   inhibit_out_a: assert property (chip_select_enable |-> !inh1_oe_n && !inh1_n_o)
      else $error("inhibit-out missing");
   lane_pair_a: assert property (!dat_oe_n[1] |-> !dat_oe_n[0])
      else $error("high lane alone");
   ack_wait_a: assert property (qual_up |-> xack_n_o [*3])
      else $error("ack before count");
   ack_release_a: assert property (qual_down |-> ##[0:2] (xack_oe_n && xack_n_o))
      else $error("ack not released");
   inh_block_a: assert property (!inh2_n [*8] |-> xack_oe_n && inh1_oe_n)
      else $error("response while inhibited");
endmodule : rbrc_top_sva

bind rbrc_top rbrc_top_sva u_sva (.pclk, .presetn, .psel, .penable,
   .pready, .inh2_n, .dat_oe_n, .xack_n_o, .xack_oe_n, .inh1_n_o,
   .inh1_oe_n, .row_select, .chip_select_enable);

// [rbrc_master_model.sv]
/*
 * Bus master model: issues memory reads, waits for the acknowledge.
 * Assumes pulled-up acknowledge and data lines when not driven.
 */
`timescale 1ns/1ps
module rbrc_master_model (
   input wire logic pclk,
   input wire logic [15:0] dat_n_o,
   input wire logic [1:0] dat_oe_n,
   input wire logic xack_n_o,
   input wire logic xack_oe_n,
   output logic [19:0] adr_n,
   output logic mrdc_n,
   output logic inh2_n,
   output logic bhen_n,
   output logic cclk_n
);
   logic xack_w;
   assign xack_w = xack_oe_n | xack_n_o;
   initial begin
      adr_n = 20'hF_FFFF;
      mrdc_n = 1'b1;
      inh2_n = 1'b1;
      bhen_n = 1'b1;
      cclk_n = 1'b1;
   end
   always #51.65 cclk_n = ~cclk_n;
   task automatic read(input logic [19:0] a, input logic bh,
      input logic inh, output logic [15:0] d, output int t);
      int n;
      n = 0;
      @(posedge pclk);
      adr_n <= ~a;
      bhen_n <= ~bh;
      inh2_n <= ~inh;
      repeat (10) @(posedge pclk);
      mrdc_n <= 1'b0;
      do @(posedge pclk); while (xack_w && n++ < 600);
      d = {dat_oe_n[1] ? 8'hFF : dat_n_o[15:8],
         dat_oe_n[0] ? 8'hFF : dat_n_o[7:0]};
      t = xack_w ? -1 : n;
      mrdc_n <= 1'b1;
      adr_n <= a;
      inh2_n <= 1'b1;
   endtask : read
endmodule : rbrc_master_model

// [tb_rom_board_read_control.sv]
/*
 * Testbench: APB setup, reads through the master model, checks.
 * Assumes the checker is bound and the model drives the bus pins.
 */
`timescale 1ns/1ps
module tb_rom_board_read_control;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic pready, pslverr, e, mrdc_n, inh2_n, bhen_n, cclk_n;
   logic [19:0] adr_n;
   logic [7:0] internal_low_byte_bus = 8'h3C;
   logic [7:0] internal_high_byte_bus = 8'hA5;
   logic [15:0] dat_n_o, d;
   logic [1:0] dat_oe_n;
   logic xack_n_o, xack_oe_n, inh1_n_o, inh1_oe_n;
   logic upper_half_select, chip_select_enable;
   logic [3:0] row_select;
   logic [13:0] internal_addr;
   int t;
   int mismatches = 0;
   int checks_done = 0;

   always #2.5 pclk = ~pclk;

   rbrc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .adr_n, .mrdc_n, .inh2_n,
      .bhen_n, .cclk_n, .internal_low_byte_bus, .internal_high_byte_bus,
      .dat_n_o, .dat_oe_n, .xack_n_o, .xack_oe_n, .inh1_n_o, .inh1_oe_n,
      .upper_half_select, .row_select, .chip_select_enable,
      .internal_addr);
   rbrc_master_model mst (.pclk, .dat_n_o, .dat_oe_n, .xack_n_o,
      .xack_oe_n, .adr_n, .mrdc_n, .inh2_n, .bhen_n, .cclk_n);

   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
      if (pready !== 1'b1) begin
         mismatches++;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [19:0] a, input logic bh, input logic inh);
      repeat (12) @(posedge pclk);
      mst.read(a, bh, inh, d, t);
   endtask : rd
   task acc(input int lo, input int hi);
      chk("ack time", 32'(t >= lo && t <= hi), 32'h0000_0001);
   endtask : acc
   task look(input logic [15:0] xd, input logic [3:0] xr, input logic xu);
      chk("data", 32'(d), 32'(xd));
      chk("row", 32'(row_select), 32'(xr));
      chk("half", 32'(upper_half_select), 32'(xu));
   endtask : look

   task t_regs;
      apb(1'b0, rbrc_pkg::CTRL_OFS, 32'h0000_0000);
      chk("ctrl", r, rbrc_pkg::CTRL_RST);
      apb(1'b0, rbrc_pkg::SEG_OFS, 32'h0000_0000);
      chk("seg", r, rbrc_pkg::SEG_RST);
      apb(1'b0, rbrc_pkg::PAGE_OFS, 32'h0000_0000);
      chk("page", r, rbrc_pkg::PAGE_RST);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("unmapped", {r[30:0], e}, 32'h0000_0001);
      apb(1'b0, rbrc_pkg::STAT_OFS, 32'h0000_0000);
      chk("stat idle", r, 32'h0000_0000);
      apb(1'b1, rbrc_pkg::SEG_OFS, 32'h0004_000A);
      apb(1'b0, rbrc_pkg::SEG_OFS, 32'h0000_0000);
      chk("seg write", r, 32'h0004_000A);
      $display("regs done");
   endtask : t_regs
   task t_byte8;
      apb(1'b1, rbrc_pkg::CTRL_OFS, 32'h0000_0022);
      rd(20'h0_1000, 1'b0, 1'b0);
      look(16'h5AC3, 4'h4, 1'b0);
      acc(40, 77);
      chk("qual", 32'(chip_select_enable), 32'h0000_0001);
      rd(20'h0_3000, 1'b0, 1'b0);
      look(16'hFF5A, 4'h4, 1'b0);
      rd(20'h0_3000, 1'b1, 1'b0);
      look(16'hFF5A, 4'h4, 1'b0);
      rd(20'h0_2000, 1'b0, 1'b0);
      look(16'hFF5A, 4'h1, 1'b1);
      $display("byte mode done");
   endtask : t_byte8
   task t_word16;
      apb(1'b1, rbrc_pkg::CTRL_OFS, 32'h0000_0023);
      rd(20'h0_1001, 1'b0, 1'b0);
      look(16'hFF5A, 4'h2, 1'b0);
      chk("iaddr", 32'(internal_addr), 32'h0000_0800);
      rd(20'h0_1000, 1'b0, 1'b0);
      look(16'h5AC3, 4'h2, 1'b0);
      rd(20'h0_1001, 1'b1, 1'b0);
      look(16'h5AC3, 4'h2, 1'b0);
      $display("word mode done");
   endtask : t_word16
   task t_ovl;
      apb(1'b1, rbrc_pkg::CTRL_OFS, 32'h0000_0122);
      rd(20'h0_1000, 1'b0, 1'b0);
      acc(300, 350);
      chk("inh1", 32'({inh1_oe_n, inh1_n_o}), 32'h0000_0000);
      rd(20'h0_3000, 1'b0, 1'b0);
      acc(40, 77);
      $display("overlap done");
   endtask : t_ovl
   task t_block;
      rd(20'h0_1000, 1'b0, 1'b1);
      chk("inhibited", 32'(t), 32'hFFFF_FFFF);
      chk("idle data", 32'(d), 32'h0000_FFFF);
      rd(20'h0_5000, 1'b0, 1'b0);
      chk("seg miss", 32'(t), 32'hFFFF_FFFF);
      apb(1'b1, rbrc_pkg::PAGE_OFS, 32'h0000_1010);
      rd(20'h1_2000, 1'b0, 1'b0);
      look(16'hFF5A, 4'h1, 1'b1);
      rd(20'h0_2000, 1'b0, 1'b0);
      chk("page miss", 32'(t), 32'hFFFF_FFFF);
      $display("block done");
   endtask : t_block

   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_byte8;
      t_word16;
      t_ovl;
      t_block;
      complete_run;
   end
   initial begin
      #200us;
      mismatches++;
      complete_run;
   end
endmodule : tb_rom_board_read_control
